// ===== verilog/ram_io_pkg.sv
package ram_io_pkg;

   // ====================
   // Address space
   localparam int ADDR_W        = 24;
   localparam int LW_W          = 22;
   localparam int LANE_W        = 2;
   localparam int RAM_BYTES     = 1024;
   localparam int RAM_WORDS     = 256;
   localparam int RAM_IDX_W     = 8;
   localparam int RAM_BASE_LSB  = 10;
   localparam int RAM_BASE_W    = 14;
   localparam int IO_BASE_LSB   = 16;
   localparam int IO_BASE_W     = 8;
   localparam logic [15:0] IO_FIRST_OFFSET = 16'hFE00;

   // Long-word indices of the register-bank part of the RAM.
   localparam logic [7:0]  BANK_FIRST_IDX  = 8'h00;
   localparam logic [7:0]  BANK_LAST_IDX   = 8'h7F;
   localparam logic [31:0] BANK_UNDEF_DATA = 32'hFFFF_FFFF;
   localparam logic [31:0] RESERVED_DATA   = 32'h0000_0000;

   // ====================
   // Register map, byte offsets on the control bus
   localparam int CSR_ADDR_W = 5;
   localparam logic [4:0] BANK_MODE_OFF  = 5'h00;
   localparam logic [4:0] RAM_BASE_OFF   = 5'h04;
   localparam logic [4:0] IO_BASE_OFF    = 5'h08;
   localparam logic [4:0] MEM_CTRL_OFF   = 5'h0C;
   localparam logic [4:0] STATUS_OFF     = 5'h10;

   localparam int RAM_EN_BIT     = 0;
   localparam int BANK_DATA_BIT  = 1;
   localparam int SUPV_ONLY_BIT  = 2;
   localparam int ADDRESS_SETUP_WAIT_BIT_BIT       = 0;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_VIOL_BIT  = 1;
   localparam int STAT_TGT_LSB   = 2;

   localparam logic [2:0]  BANK_MODE_RST = 3'h0;
   localparam logic [13:0] RAM_BASE_RST  = 14'h0000;
   localparam logic [7:0]  IO_BASE_RST   = 8'h00;
   localparam logic        ADDRESS_SETUP_WAIT_BIT_RST      = 1'b0;

   // ====================
   // Types
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2
   } size_t;

   typedef enum logic [2:0] {
      TGT_EXT = 3'h1,
      TGT_RAM = 3'h2,
      TGT_IO  = 3'h4
   } target_t;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_RAM_A    = 9'h002,
      ST_RAM_B    = 9'h004,
      ST_IO_SETUP = 9'h008,
      ST_IO_T1    = 9'h010,
      ST_IO_T2    = 9'h020,
      ST_IO_T3    = 9'h040,
      ST_EXT      = 9'h080,
      ST_DONE     = 9'h100
   } state_t;

   typedef struct packed {
      logic [23:0] addr;
      size_t       size;
      logic        write;
      logic        fetch;
      logic        supervisor;
      logic [31:0] wdata;
   } access_req_t;

   typedef struct packed {
      logic        ack;
      logic        violation;
      logic [31:0] rdata;
   } access_rsp_t;

   typedef struct packed {
      logic [21:0] lw_addr;
      logic [3:0]  be;
      logic        write;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic [3:0]      be;
      logic [3:0][4:0] pos;
      logic [31:0]     wdata;
   } lane_map_t;

endpackage : ram_io_pkg

// ===== verilog/ram_store.sv
`timescale 1ns/1ps

module ram_store #(
   parameter int WORDS = ram_io_pkg::RAM_WORDS,
   parameter int IDX_W = ram_io_pkg::RAM_IDX_W
) (
   input  wire logic             sys_clk_i,
   input  wire logic             en_i,
   input  wire logic             we_i,
   input  wire logic [IDX_W-1:0] idx_i,
   input  wire logic [3:0]       be_i,
   input  wire logic [31:0]      wdata_i,
   output logic      [31:0]      rdata_o
);

   // No reset and no preload: contents are whatever the cells hold.
   logic [31:0] mem [WORDS]; // [R9]

   always_ff @(posedge sys_clk_i) begin
      if (en_i) begin
         for (int b = 0; b < 4; b++) begin
            if (we_i && be_i[b]) begin
               mem[idx_i][8*b +: 8] <= wdata_i[8*b +: 8];
            end
         end
         rdata_o <= mem[idx_i];
      end
   end

endmodule : ram_store

// ===== verilog/target_decode.sv
`timescale 1ns/1ps

module target_decode (
   input  wire logic [23:0]        addr_i,
   input  wire logic               fetch_i,
   input  wire logic               ram_en_i,
   input  wire logic [13:0]        ram_base_i,
   input  wire logic [7:0]         io_base_i,
   output ram_io_pkg::target_t     tgt_o
);

   logic [23:0] ram_first;
   logic [23:0] ram_offset;
   logic        ram_hit;
   logic        io_hit;

   assign ram_first  = {ram_base_i, {ram_io_pkg::RAM_BASE_LSB{1'b0}}};
   assign ram_offset = addr_i - ram_first; // [R18]
   // Fetches never land in RAM; they fall through to the I/O window or the bus.
   assign ram_hit = ram_en_i && !fetch_i && // [R1] [R2]
                    (ram_offset < 24'(ram_io_pkg::RAM_BYTES));
   assign io_hit  = (addr_i[23:ram_io_pkg::IO_BASE_LSB] == io_base_i) &&
                    (addr_i[ram_io_pkg::IO_BASE_LSB-1:0] >=
                     ram_io_pkg::IO_FIRST_OFFSET); // [R11] [R12]

   // RAM takes priority where both windows overlap.
   always_comb begin
      if (ram_hit) begin
         tgt_o = ram_io_pkg::TGT_RAM;
      end else if (io_hit) begin
         tgt_o = ram_io_pkg::TGT_IO;
      end else begin
         tgt_o = ram_io_pkg::TGT_EXT;
      end
   end

endmodule : target_decode

// ===== verilog/ram_io_decode.sv
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

// Overview of operation
// [R1] Instruction fetches in the RAM range go to external memory.
// [R2] RAM enable clear lets the peripheral at that address answer.
// [R3] Bank area without bank-as-data: reads undefined, writes dropped.
// [R4] Bank area with bank-as-data: ordinary read/write data memory.
// [R5] Supervisor-only clear: user state may access RAM.
// [R6] Supervisor-only set: user RAM access raises access violation.
// [R7] RAM cycles keep address and byte strobes inactive.
// [R8] Access from top of RAM wraps to lowest RAM locations.
// [R9] RAM contents are not initialised by reset.
// [R10] RAM access within one long word takes two clocks.
// [R11] I/O window base set in 64-kbyte steps by its base register.
// [R12] Only offsets FE00 to FFFF of the window are internal I/O.
// [R13] Internal I/O cycle is three states; wait requests ignored.
// [R14] Address-setup wait bit adds a setup prestate before T1.
// [R15] Internal I/O cycles keep external strobes inactive.
// [R16] User-state internal I/O access raises access violation.
// [R17] Reserved internal I/O locations read as zero.
// [R18] RAM address is base bits 23-10 plus the 10-bit offset.
// [R19] Misaligned RAM access takes four clocks.
// [R20] Each portion of a split access goes to its own target.
module ram_io_decode (
   input  wire logic                    sys_clk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic [4:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   input  wire logic                    req_valid_i,
   input  ram_io_pkg::access_req_t      req_i,
   output ram_io_pkg::access_rsp_t      rsp_o,
   output logic                         ext_valid_o,
   output ram_io_pkg::bus_req_t         ext_o,
   input  wire logic                    ext_done_i,
   input  wire logic [31:0]             ext_rdata_i,
   output logic                         io_valid_o,
   output ram_io_pkg::bus_req_t         io_o,
   input  wire logic                    io_claim_i,
   input  wire logic [31:0]             io_rdata_i,
   output logic                         address_strobe_n_o,
   output logic                         upper_byte_strobe_n_o,
   output logic                         lower_byte_strobe_n_o
);

   // ====================
   // Helpers
   function automatic logic [2:0] byte_count(
      input ram_io_pkg::size_t sz);
      case (sz)
         ram_io_pkg::SIZE_WORD: byte_count = 3'h2;
         ram_io_pkg::SIZE_LONG: byte_count = 3'h4;
         default:               byte_count = 3'h1;
      endcase
   endfunction : byte_count

   // An access that spills past its long word needs a second portion.
   function automatic logic two_parts(
      input ram_io_pkg::access_req_t r);
      two_parts = ({1'b0, r.addr[1:0]} + byte_count(r.size)) > 3'h4;
   endfunction : two_parts

   // Byte lanes of one portion; data is right-aligned, lowest address
   // carrying the most significant byte.
   function automatic ram_io_pkg::lane_map_t lane_map(
      input ram_io_pkg::access_req_t r,
      input logic                    part);
      int k;
      int n;
      int pos;
      k = 0;
      pos = 0;
      lane_map = '0;
      n = int'(byte_count(r.size));
      for (int l = 0; l < 4; l++) begin
         k = l + (part ? 4 : 0) - int'(r.addr[1:0]);
         if (k >= 0 && k < n) begin
            pos = 8 * (n - 1 - k);
            lane_map.be[3-l]  = 1'b1;
            lane_map.pos[3-l] = 5'(pos);
            lane_map.wdata[8*(3-l) +: 8] = r.wdata[pos +: 8];
         end
      end
   endfunction : lane_map

   function automatic logic [31:0] merge(
      input logic [31:0]           acc,
      input ram_io_pkg::lane_map_t m,
      input logic [31:0]           src);
      merge = acc;
      for (int b = 0; b < 4; b++) begin
         if (m.be[b]) begin
            merge[m.pos[b] +: 8] = src[8*b +: 8];
         end
      end
   endfunction : merge

   // The second portion after a RAM first portion stays in RAM.
   function automatic logic [21:0] part_lw(
      input ram_io_pkg::access_req_t r,
      input logic                    part,
      input logic                    wrap);
      part_lw = r.addr[ram_io_pkg::ADDR_W-1:ram_io_pkg::LANE_W];
      if (part) begin
         if (wrap) begin
            part_lw[ram_io_pkg::RAM_IDX_W-1:0] =
               part_lw[ram_io_pkg::RAM_IDX_W-1:0] + 8'h01; // [R8]
         end else begin
            part_lw = part_lw + 22'h00_0001;
         end
      end
   endfunction : part_lw

   function automatic logic [31:0] be_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0]  be);
      be_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            be_merge[8*b +: 8] = wd[8*b +: 8];
         end
      end
   endfunction : be_merge

   // ====================
   // Control registers
   logic [2:0]                bank_mode_q;
   logic [13:0]               ram_base_q;
   logic [7:0]                io_base_q;
   logic                      address_setup_wait_bit_q;
   logic                      viol_seen_q;
   ram_io_pkg::target_t       last_tgt_q;
   logic                      wait_q;
   logic [31:0]               csr_image;
   logic [31:0]               csr_new;
   logic                      csr_wr;
   ram_io_pkg::state_t        state_q;
   ram_io_pkg::state_t        state_d;
   logic                      viol_event;

   always_comb begin
      csr_image = 32'h0000_0000;
      case (avs_address)
         ram_io_pkg::BANK_MODE_OFF: csr_image[2:0] = bank_mode_q;
         ram_io_pkg::RAM_BASE_OFF:
            csr_image[23:ram_io_pkg::RAM_BASE_LSB] = ram_base_q;
         ram_io_pkg::IO_BASE_OFF:
            csr_image[23:ram_io_pkg::IO_BASE_LSB] = io_base_q;
         ram_io_pkg::MEM_CTRL_OFF:
            csr_image[ram_io_pkg::ADDRESS_SETUP_WAIT_BIT_BIT] = address_setup_wait_bit_q;
         ram_io_pkg::STATUS_OFF: begin
            csr_image[ram_io_pkg::STAT_BUSY_BIT] =
               (state_q != ram_io_pkg::ST_IDLE);
            csr_image[ram_io_pkg::STAT_VIOL_BIT] = viol_seen_q;
            csr_image[ram_io_pkg::STAT_TGT_LSB +: 3] = last_tgt_q;
         end
         default: csr_image = 32'h0000_0000;
      endcase
   end

   assign csr_new = be_merge(csr_image, avs_writedata, avs_byteenable);
   assign csr_wr  = avs_write && !wait_q;

   // One wait cycle on every access; the answer comes in the second.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wait_q       <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
         if (avs_read && wait_q) begin
            avs_readdata <= csr_image;
         end
      end
   end

   assign avs_waitrequest = wait_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         bank_mode_q <= ram_io_pkg::BANK_MODE_RST;
         ram_base_q  <= ram_io_pkg::RAM_BASE_RST;
         io_base_q   <= ram_io_pkg::IO_BASE_RST;
         address_setup_wait_bit_q      <= ram_io_pkg::ADDRESS_SETUP_WAIT_BIT_RST;
      end else if (csr_wr) begin
         case (avs_address)
            ram_io_pkg::BANK_MODE_OFF: bank_mode_q <= csr_new[2:0];
            ram_io_pkg::RAM_BASE_OFF:
               ram_base_q <= csr_new[23:ram_io_pkg::RAM_BASE_LSB];
            ram_io_pkg::IO_BASE_OFF:
               io_base_q <= csr_new[23:ram_io_pkg::IO_BASE_LSB];
            ram_io_pkg::MEM_CTRL_OFF:
               address_setup_wait_bit_q <= csr_new[ram_io_pkg::ADDRESS_SETUP_WAIT_BIT_BIT];
            default: ;
         endcase
      end
   end

   // A violation in the same cycle as a write-one clear stays set.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         viol_seen_q <= 1'b0;
      end else if (viol_event) begin
         viol_seen_q <= 1'b1;
      end else if (csr_wr && avs_address == ram_io_pkg::STATUS_OFF &&
                   avs_byteenable[0] &&
                   avs_writedata[ram_io_pkg::STAT_VIOL_BIT]) begin
         viol_seen_q <= 1'b0;
      end
   end

   // ====================
   // Dispatch of one access portion
   ram_io_pkg::access_req_t   acc_q;
   logic                      part_q;
   logic                      first_ram_q;
   ram_io_pkg::access_req_t   disp_req;
   logic                      disp_part;
   logic [21:0]               disp_lw;
   ram_io_pkg::lane_map_t     disp_map;
   ram_io_pkg::target_t       dec_tgt;
   ram_io_pkg::target_t       disp_tgt;
   logic                      disp_viol;
   logic                      disp_go;
   ram_io_pkg::state_t        disp_next;
   logic                      part_end;
   logic                      more;

   assign disp_part = (state_q != ram_io_pkg::ST_IDLE);
   assign disp_req  = disp_part ? acc_q : req_i;
   assign disp_lw   = part_lw(disp_req, disp_part, first_ram_q);
   assign disp_map  = lane_map(disp_req, disp_part);

   target_decode u_decode (
      .addr_i     ({disp_lw, disp_part ? 2'h0 : disp_req.addr[1:0]}),
      .fetch_i    (disp_req.fetch),
      .ram_en_i   (bank_mode_q[ram_io_pkg::RAM_EN_BIT]),
      .ram_base_i (ram_base_q),
      .io_base_i  (io_base_q),
      .tgt_o      (dec_tgt)
   );

   // Each portion is decoded on its own address, except a second portion after a RAM first portion, which stays in RAM.
   assign disp_tgt = (disp_part && first_ram_q) ?
                     ram_io_pkg::TGT_RAM : dec_tgt; // [R8] [R20]

   assign disp_viol = !disp_req.supervisor &&
      ((disp_tgt == ram_io_pkg::TGT_RAM &&
        bank_mode_q[ram_io_pkg::SUPV_ONLY_BIT]) || // [R5] [R6]
       disp_tgt == ram_io_pkg::TGT_IO); // [R16]

   assign more     = !part_q && two_parts(acc_q); // [R19]
   assign part_end = (state_q == ram_io_pkg::ST_RAM_B) ||
                     (state_q == ram_io_pkg::ST_IO_T3) ||
                     (state_q == ram_io_pkg::ST_EXT && ext_done_i);
   assign disp_go  = (state_q == ram_io_pkg::ST_IDLE && req_valid_i) ||
                     (part_end && more);
   assign viol_event = disp_go && disp_viol;

   always_comb begin
      if (disp_viol) begin
         disp_next = ram_io_pkg::ST_DONE;
      end else begin
         case (disp_tgt)
            ram_io_pkg::TGT_RAM: disp_next = ram_io_pkg::ST_RAM_A;
            ram_io_pkg::TGT_IO:
               disp_next = address_setup_wait_bit_q ? ram_io_pkg::ST_IO_SETUP
                                  : ram_io_pkg::ST_IO_T1; // [R14]
            default: disp_next = ram_io_pkg::ST_EXT;
         endcase
      end
   end

   // ====================
   // Cycle sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ram_io_pkg::ST_IDLE:
            if (req_valid_i) state_d = disp_next;
         ram_io_pkg::ST_RAM_A: state_d = ram_io_pkg::ST_RAM_B; // [R10]
         ram_io_pkg::ST_IO_SETUP: state_d = ram_io_pkg::ST_IO_T1;
         ram_io_pkg::ST_IO_T1: state_d = ram_io_pkg::ST_IO_T2; // [R13]
         ram_io_pkg::ST_IO_T2: state_d = ram_io_pkg::ST_IO_T3;
         ram_io_pkg::ST_RAM_B, ram_io_pkg::ST_IO_T3:
            state_d = more ? disp_next : ram_io_pkg::ST_DONE;
         ram_io_pkg::ST_EXT:
            if (ext_done_i) begin
               state_d = more ? disp_next : ram_io_pkg::ST_DONE;
            end
         ram_io_pkg::ST_DONE: state_d = ram_io_pkg::ST_IDLE;
         default: state_d = ram_io_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= ram_io_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   ram_io_pkg::lane_map_t     part_map_q;
   logic [21:0]               part_lw_q;
   logic [31:0]               data_q;
   logic                      viol_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         acc_q       <= '0;
         part_q      <= 1'b0;
         first_ram_q <= 1'b0;
         part_map_q  <= '0;
         part_lw_q   <= '0;
         viol_q      <= 1'b0;
         last_tgt_q  <= ram_io_pkg::TGT_EXT;
      end else if (disp_go) begin
         part_q     <= disp_part;
         part_map_q <= disp_map;
         part_lw_q  <= disp_lw;
         viol_q     <= disp_viol;
         last_tgt_q <= disp_tgt;
         if (!disp_part) begin
            acc_q       <= req_i;
            first_ram_q <= (disp_tgt == ram_io_pkg::TGT_RAM);
         end
      end
   end

   // ====================
   // Internal RAM
   logic                      bank_blocked;
   logic [31:0]               ram_rdata;
   logic [31:0]               cap_src;
   logic [31:0]               data_next;

   assign bank_blocked = !bank_mode_q[ram_io_pkg::BANK_DATA_BIT] &&
      part_lw_q[7:0] >= ram_io_pkg::BANK_FIRST_IDX &&
      part_lw_q[7:0] <= ram_io_pkg::BANK_LAST_IDX;

   ram_store #(
      .WORDS (ram_io_pkg::RAM_WORDS),
      .IDX_W (ram_io_pkg::RAM_IDX_W)
   ) u_ram (
      .sys_clk_i (sys_clk_i),
      .en_i      (state_q == ram_io_pkg::ST_RAM_A),
      .we_i      (acc_q.write && !bank_blocked), // [R3] [R4]
      .idx_i     (part_lw_q[ram_io_pkg::RAM_IDX_W-1:0]),
      .be_i      (part_map_q.be),
      .wdata_i   (part_map_q.wdata),
      .rdata_o   (ram_rdata)
   );

   always_comb begin
      case (state_q)
         ram_io_pkg::ST_RAM_B:
            cap_src = bank_blocked ? ram_io_pkg::BANK_UNDEF_DATA
                                   : ram_rdata; // [R3]
         ram_io_pkg::ST_IO_T3:
            cap_src = io_claim_i ? io_rdata_i
                                 : ram_io_pkg::RESERVED_DATA; // [R17]
         default: cap_src = ext_rdata_i;
      endcase
   end

   assign data_next = part_end ? merge(data_q, part_map_q, cap_src)
                               : data_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         data_q <= 32'h0000_0000;
      end else if (state_q == ram_io_pkg::ST_IDLE) begin
         data_q <= 32'h0000_0000;
      end else begin
         data_q <= data_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rsp_o <= '0;
      end else begin
         rsp_o.ack <= (state_d == ram_io_pkg::ST_DONE) &&
                      (state_q != ram_io_pkg::ST_DONE);
         if (state_d == ram_io_pkg::ST_DONE &&
             state_q != ram_io_pkg::ST_DONE) begin
            rsp_o.violation <= viol_event || viol_q;
            rsp_o.rdata     <= viol_event ? data_q : data_next;
         end
      end
   end

   // ====================
   // Internal I/O and external bus
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         io_o       <= '0;
         io_valid_o <= 1'b0;
      end else begin
         if (disp_go && disp_next == ram_io_pkg::ST_IO_T1 ||
             disp_go && disp_next == ram_io_pkg::ST_IO_SETUP) begin
            io_o <= '{disp_lw, disp_map.be, disp_req.write,
                      disp_map.wdata};
         end
         // Strobe only in T1; ready or wait inputs are not consulted.
         io_valid_o <= (state_d == ram_io_pkg::ST_IO_T1); // [R13]
      end
   end

   // Strobes fall only for external portions, never for RAM or I/O.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ext_o                 <= '0;
         ext_valid_o           <= 1'b0;
         address_strobe_n_o    <= 1'b1;
         upper_byte_strobe_n_o <= 1'b1;
         lower_byte_strobe_n_o <= 1'b1;
      end else if (disp_go && disp_next == ram_io_pkg::ST_EXT) begin
         ext_o <= '{disp_lw, disp_map.be, disp_req.write,
                    disp_map.wdata};
         ext_valid_o           <= 1'b1;
         address_strobe_n_o    <= 1'b0;
         upper_byte_strobe_n_o <= !(disp_map.be[3] || disp_map.be[1]);
         lower_byte_strobe_n_o <= !(disp_map.be[2] || disp_map.be[0]);
      end else if (state_d != ram_io_pkg::ST_EXT) begin
         ext_valid_o           <= 1'b0;
         address_strobe_n_o    <= 1'b1; // [R7] [R15]
         upper_byte_strobe_n_o <= 1'b1;
         lower_byte_strobe_n_o <= 1'b1;
      end
   end

endmodule : ram_io_decode

// ===== testbench/ram_io_chk_asserts.sv
`timescale 1ns/1ps
module ram_io_chk (
   input wire logic sys_clk_i, sys_rst_i, avs_read, avs_waitrequest,
   input wire logic req_valid_i, ext_valid_o, ext_done_i, io_valid_o,
   input wire logic address_strobe_n_o, upper_byte_strobe_n_o,
   input wire logic lower_byte_strobe_n_o,
   input ram_io_pkg::bus_req_t ext_o,
   input ram_io_pkg::access_req_t req_i,
   input ram_io_pkg::access_rsp_t rsp_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   strobe_ext_only_a: assert property (
      !address_strobe_n_o |-> ext_valid_o) else $error("strobe no ext");
   io_no_strobe_a: assert property (
      io_valid_o |-> address_strobe_n_o [*3]) else $error("io strobe");
   io_three_a: assert property (
      io_valid_o && req_i.size == ram_io_pkg::SIZE_BYTE |-> ##3 rsp_o.ack)
      else $error("io length");
   io_super_a: assert property (
      io_valid_o |-> req_i.supervisor) else $error("user io cycle");
   csr_wait_a: assert property (
      $rose(avs_read) |=> !avs_waitrequest) else $error("csr wait");
   ack_pulse_a: assert property (
      rsp_o.ack |=> !rsp_o.ack) else $error("ack width");
   fetch_not_ram_a: assert property (
      $rose(req_valid_i) && req_i.fetch
      |=> ##[0:1] (ext_valid_o || io_valid_o || rsp_o.ack))
      else $error("fetch in ram");
   lane_strobe_a: assert property (
      !address_strobe_n_o |-> upper_byte_strobe_n_o ==
      !(ext_o.be[3] || ext_o.be[1]) && lower_byte_strobe_n_o ==
      !(ext_o.be[2] || ext_o.be[0])) else $error("byte strobes");
   ext_end_a: assert property (
      ext_done_i && ext_valid_o |=> !ext_valid_o && address_strobe_n_o)
      else $error("ext end");
endmodule : ram_io_chk
bind ram_io_decode ram_io_chk u_chk (.*);

// ===== testbench/ext_io_partner.sv
`timescale 1ns/1ps
module ext_io_partner #(parameter int LAT = 2) (
   input  wire logic             sys_clk_i, ext_valid_o, io_valid_o,
   input  ram_io_pkg::bus_req_t  ext_o, io_o,
   output logic                  ext_done_i, io_claim_i,
   output logic [31:0]           ext_rdata_i, io_rdata_i
);
   logic [3:0] cnt_q;
   // Off the done cycle the data is inverted so stale reads show up.
   assign ext_rdata_i = {16'hA5A5, ext_o.lw_addr[15:0]} ^ {32{!ext_done_i}};
   assign io_rdata_i  = {16'hA5A5, io_o.lw_addr[15:0]};
   assign io_claim_i  = io_o.lw_addr[13:0] >= 14'h3FCA;
   always_ff @(posedge sys_clk_i) begin
      cnt_q      <= (ext_valid_o && !ext_done_i) ? cnt_q + 4'h1 : 4'h0;
      ext_done_i <= ext_valid_o && !ext_done_i && cnt_q == LAT[3:0];
   end
endmodule : ext_io_partner

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst = 1, rd = 0, wr = 0, rv = 0, wq, v;
   logic ev, ed, iv, ic, as_n, ub_n, lb_n;
   logic [4:0] adr = 0;
   logic [31:0] wd = 0, rdat, q, er, ir;
   ram_io_pkg::access_req_t rq = '0;
   ram_io_pkg::access_rsp_t rsp;
   ram_io_pkg::bus_req_t eo, io;
   int n, miscompares = 0, total_checks = 0;
   ram_io_decode u_dut (.sys_clk_i(clk), .sys_rst_i(rst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wq), .req_valid_i(rv), .req_i(rq), .rsp_o(rsp),
      .ext_valid_o(ev), .ext_o(eo), .ext_done_i(ed), .ext_rdata_i(er),
      .io_valid_o(iv), .io_o(io), .io_claim_i(ic), .io_rdata_i(ir),
      .address_strobe_n_o(as_n), .upper_byte_strobe_n_o(ub_n),
      .lower_byte_strobe_n_o(lb_n));
   ext_io_partner u_far (.sys_clk_i(clk), .ext_valid_o(ev),
      .io_valid_o(iv), .ext_o(eo), .io_o(io), .ext_done_i(ed),
      .io_claim_i(ic), .ext_rdata_i(er), .io_rdata_i(ir));
   initial forever #5 clk = ~clk;
   // ====================
   // Checking and bus tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic csr(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      wr <= w; rd <= !w; adr <= a; wd <= d;
      for (n = 0; n < 20 && wq !== 1'b0; n++) @(posedge clk);
      q = rdat; wr <= 0; rd <= 0;
      if (n == 20) begin miscompares++; give_verdict; end
   endtask : csr
   task automatic ac(input logic [23:0] a, input ram_io_pkg::size_t s,
                     input logic w, f, sp, input logic [31:0] d);
      @(posedge clk);
      rv <= 1; rq <= '{a, s, w, f, sp, d};
      n = 0;
      do begin @(posedge clk); n++; end while (rsp.ack !== 1'b1 && n < 50);
      rv <= 0; q = rsp.rdata; v = rsp.violation;
      if (n == 50) begin miscompares++; give_verdict; end
   endtask : ac
   // ====================
   // Scenarios
   task automatic t_csr;
      csr(0, ram_io_pkg::BANK_MODE_OFF, 0); chk(q, 0);
      csr(1, 5'h14, 32'hFFFF_FFFF); csr(0, 5'h14, 0); chk(q, 0);
      $display("t_csr done");
   endtask : t_csr
   task automatic t_ram;
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 0, 0, 1, 0);
      chk(q, 32'hA5A5_0180);
      csr(1, ram_io_pkg::BANK_MODE_OFF, 32'h0000_0001);
      csr(1, ram_io_pkg::RAM_BASE_OFF, 32'h0000_0400);
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 1, 0, 1, 32'h1234_5678);
      chk(n, 4); chk(as_n, 1);
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 0, 0, 1, 0);
      chk(q, 32'h1234_5678); chk(n, 4);
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 0, 1, 1, 0);
      chk(q, 32'hA5A5_0180);
      ac(24'h00_0400, ram_io_pkg::SIZE_LONG, 1, 0, 1, 32'hCAFE_F00D);
      ac(24'h00_0400, ram_io_pkg::SIZE_LONG, 0, 0, 1, 0);
      chk(q, 32'hFFFF_FFFF);
      csr(1, ram_io_pkg::BANK_MODE_OFF, 32'h0000_0003);
      ac(24'h00_07FE, ram_io_pkg::SIZE_LONG, 1, 0, 1, 32'h1122_3344);
      ac(24'h00_0400, ram_io_pkg::SIZE_WORD, 0, 0, 1, 0);
      chk(q[15:0], 16'h3344);
      ac(24'h00_07FF, ram_io_pkg::SIZE_WORD, 0, 0, 1, 0);
      chk(n, 6); chk(q[15:0], 16'h2233);
      csr(1, ram_io_pkg::BANK_MODE_OFF, 32'h0000_0007);
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 0, 0, 0, 0);
      chk(v, 1); chk(n, 2);
      csr(1, ram_io_pkg::BANK_MODE_OFF, 32'h0000_0003);
      ac(24'h00_0600, ram_io_pkg::SIZE_LONG, 0, 0, 0, 0);
      chk(v, 0); chk(q, 32'h1234_5678);
      $display("t_ram done");
   endtask : t_ram
   task automatic t_io;
      csr(1, ram_io_pkg::IO_BASE_OFF, 32'h0012_0000);
      ac(24'h12_FE00, ram_io_pkg::SIZE_BYTE, 0, 0, 1, 0);
      chk(q, 0); chk(n, 5);
      ac(24'h12_FDFC, ram_io_pkg::SIZE_LONG, 0, 0, 1, 0);
      chk(q, 32'hA5A5_BF7F);
      ac(24'h12_FF28, ram_io_pkg::SIZE_BYTE, 0, 0, 0, 0);
      chk(v, 1);
      csr(0, ram_io_pkg::STATUS_OFF, 0); chk(q, 32'h0000_0012);
      csr(1, ram_io_pkg::MEM_CTRL_OFF, 32'h0000_0001);
      ac(24'h12_FF28, ram_io_pkg::SIZE_BYTE, 0, 0, 1, 0);
      chk(n, 6); chk(q[7:0], 8'hA5);
      $display("t_io done");
   endtask : t_io
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      t_csr();
      t_ram();
      t_io();
      give_verdict();
   end
endmodule : tb
